// >>> logic/deglitch_filter.sv
// Level deglitch: output rises after the input has stayed high for target cycles.
// Assumes the input is already synchronous to clk_sys and target is at least one.
`default_nettype none
`timescale 1ns/100ps
module deglitch_filter
	import processor_hot_alert_n_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Filter.
	input  wire logic             level_in,
	input  wire logic [CNT_W-1:0] target,
	output logic                  level_out
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             out_reg;
	logic             out_next;

	always_comb begin
		cnt_next = cnt_reg;
		out_next = out_reg;
		if (!level_in) begin
			cnt_next = '0;
			out_next = 1'b0;
		end else if (cnt_reg >= target - 1'b1) begin
			out_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			out_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign level_out = out_reg;
endmodule
`default_nettype wire

// >>> logic/processor_hot_alert_config.sv
// Processor-hot alert: configuration register, source comparators, deglitch and pulse.
// Assumes register writes arrive from the serial front end on clk_sys, and that the
// sense values come from a converter already synchronous to clk_sys.
// Function
// - Five-bit over-current threshold in bits 15..11, percent of input current limit.
// - Codes 1..25 give 110..230% by 5%, 26..30 give 250..450% by 50%.
// - Code all-ones is out of range; that comparator never triggers.
// - Over-current threshold field resets to the 150% code.
// - Critical threshold is 110% of over-current threshold, alerts after its deglitch.
// - Bits 10..9 pick critical deglitch 15/100/400/800 us, reset 100 us.
// - System rail below threshold triggers after a fixed 20 us deglitch.
// - Bits 7..6 pick rail threshold per cell count, reset code 01.
// - With extension bit 5 set, alert stays low until clear bit written zero.
// - Without extension, pulse lasts at least 100us/1ms/10ms/5ms per bits 4..3.
// - Writing zero to clear bit ends a held alert when no trigger is live; one is idle, reset.
// - Nominal threshold is fixed 10% above the input current limit.
// - Bit 1 picks nominal deglitch 1 ms or 50 ms, reset 1 ms.
// - Bits 8 and 0 are reserved and read zero.
// - Alert disabled whenever all profile enable bits are zero.
`default_nettype none
`timescale 1ns/100ps
module processor_hot_alert_config
	import processor_hot_alert_n_pkg::*;
#(
	parameter int CRIT_DEG1_CYC = cyc_from_us(T_CRIT_DEG1_US),
	parameter int CRIT_DEG2_CYC = cyc_from_us(T_CRIT_DEG2_US),
	parameter int CRIT_DEG3_CYC = cyc_from_us(T_CRIT_DEG3_US),
	parameter int NOM_DEG0_CYC  = cyc_from_us(T_NOM_DEG0_MS * US_PER_MS),
	parameter int NOM_DEG1_CYC  = cyc_from_us(T_NOM_DEG1_MS * US_PER_MS),
	parameter int WIDTH0_CYC    = cyc_from_us(T_WIDTH0_US),
	parameter int WIDTH1_CYC    = cyc_from_us(T_WIDTH1_MS * US_PER_MS),
	parameter int WIDTH2_CYC    = cyc_from_us(T_WIDTH2_MS * US_PER_MS),
	parameter int WIDTH3_CYC    = cyc_from_us(T_WIDTH3_MS * US_PER_MS)
) (
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// Configuration register port.
	input  wire logic              cfg_wr_en,
	input  wire logic [15:0]       cfg_wr_data,
	output logic      [15:0]       cfg_rd_data,
	// Source enables from the profile register.
	input  wire logic [PROF_W-1:0] profile_en,
	// Sensed quantities.
	input  wire sense_s            sense,
	// Alert pin and comparator status.
	output logic                   processor_hot_alert_n,
	output status_s                status
);
	logic [15:0]      cfg_reg;
	logic [15:0]      cfg_next;
	logic             clear_evt;
	logic [PCT_W-1:0] pct;
	status_s          status_reg;
	status_s          status_next;
	logic [CNT_W-1:0] deg_target [3];
	logic             deg_in     [3];
	logic             deg_out    [3];
	logic [CNT_W-1:0] crit_target;
	logic [CNT_W-1:0] nom_target;
	logic [CNT_W-1:0] width_cyc;
	logic [VOLT_W-1:0] sys_thr;
	logic             alert_on;
	logic             trig;
	alert_state_e     state_reg;
	alert_state_e     state_next;
	logic [CNT_W-1:0] width_cnt_reg;
	logic [CNT_W-1:0] width_cnt_next;
	logic             alert_n_reg;
	logic             alert_n_next;

	// Register: reserved bits never store; a zero on the clear bit is taken as a
	// one-shot command, and the bit reads back as idle one cycle later.
	assign clear_evt = cfg_wr_en && !cfg_wr_data[CLEAR_BIT];
	always_comb begin
		cfg_next = cfg_reg;
		cfg_next[CLEAR_BIT] = 1'b1;
		if (cfg_wr_en) begin
			cfg_next = cfg_wr_data & CFG_WMASK;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// Comparators, registered to keep the wide products off the deglitch path.
	assign pct = ovc_pct(cfg_reg[OVC_SEL_HI:OVC_SEL_LO]);
	always_comb begin
		sys_thr = sense.one_cell ? SYS_ONE_MV[cfg_reg[SYS_SEL_HI:SYS_SEL_LO]]
		                         : SYS_MULTI_MV[cfg_reg[SYS_SEL_HI:SYS_SEL_LO]];
		status_next.overcurrent = (pct != '0) &&
			(PROD_W'(sense.sensed_ma) * OVC_SENSE_MUL >
			 PROD_W'(sense.limit_ma) * PROD_W'(pct));
		status_next.critical = (pct != '0) &&
			(PROD_W'(sense.sensed_ma) * CRIT_SENSE_MUL >
			 PROD_W'(sense.limit_ma) * PROD_W'(pct) * CRIT_LIM_MUL);
		status_next.nominal = PROD_W'(sense.sensed_ma) * NOM_SENSE_MUL >
			PROD_W'(sense.limit_ma) * NOM_LIM_MUL;
		status_next.undervoltage = sense.system_rail_mv < sys_thr;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// Deglitch and width selects.
	always_comb begin
		unique case (cfg_reg[CRIT_DEG_HI:CRIT_DEG_LO])
			2'h0: crit_target = CNT_W'(CRIT_DEG0_CYC);
			2'h1: crit_target = CNT_W'(CRIT_DEG1_CYC);
			2'h2: crit_target = CNT_W'(CRIT_DEG2_CYC);
			2'h3: crit_target = CNT_W'(CRIT_DEG3_CYC);
		endcase
		nom_target = cfg_reg[NOM_DEG_BIT] ? CNT_W'(NOM_DEG1_CYC) : CNT_W'(NOM_DEG0_CYC);
		unique case (cfg_reg[WIDTH_HI:WIDTH_LO])
			2'h0: width_cyc = CNT_W'(WIDTH0_CYC);
			2'h1: width_cyc = CNT_W'(WIDTH1_CYC);
			2'h2: width_cyc = CNT_W'(WIDTH2_CYC);
			2'h3: width_cyc = CNT_W'(WIDTH3_CYC);
		endcase
	end

	assign deg_in[0]     = status_reg.critical;
	assign deg_in[1]     = status_reg.nominal;
	assign deg_in[2]     = status_reg.undervoltage;
	assign deg_target[0] = crit_target;
	assign deg_target[1] = nom_target;
	assign deg_target[2] = CNT_W'(SYS_DEG_CYC);

	for (genvar i = 0; i < 3; i++) begin : g_deglitch
		deglitch_filter u_filter (
			.clk_sys   (clk_sys),
			.rstn      (rstn),
			.level_in  (deg_in[i]),
			.target    (deg_target[i]),
			.level_out (deg_out[i])
		);
	end

	assign alert_on = |profile_en;
	assign trig = alert_on && ((deg_out[0] && profile_en[PROF_CRIT_BIT]) ||
	                           (deg_out[1] && profile_en[PROF_NOM_BIT]) ||
	                           (deg_out[2] && profile_en[PROF_SYS_BIT]));

	// Alert sequencer. A trigger in the same cycle as a clear keeps the alert held,
	// so no event is lost to a racing host write.
	always_comb begin
		state_next     = state_reg;
		width_cnt_next = width_cnt_reg;
		unique case (state_reg)
			ALERT_IDLE: begin
				if (trig) begin
					state_next     = cfg_reg[EXT_EN_BIT] ? ALERT_HELD : ALERT_ACTIVE;
					width_cnt_next = width_cyc - 1'b1;
				end
			end
			ALERT_ACTIVE: begin
				if (cfg_reg[EXT_EN_BIT]) begin
					state_next = ALERT_HELD;
				end else if (trig) begin
					width_cnt_next = width_cyc - 1'b1;
				end else if (width_cnt_reg == '0) begin
					state_next = ALERT_IDLE;
				end else begin
					width_cnt_next = width_cnt_reg - 1'b1;
				end
			end
			ALERT_HELD: begin
				if (clear_evt && !trig) begin
					state_next = ALERT_IDLE;
				end
			end
			default: begin
				state_next = ALERT_IDLE;
			end
		endcase
		if (!alert_on) begin
			state_next = ALERT_IDLE;
		end
		alert_n_next = (state_next == ALERT_IDLE);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg     <= ALERT_IDLE;
			width_cnt_reg <= '0;
			alert_n_reg   <= 1'b1;
		end else begin
			state_reg     <= state_next;
			width_cnt_reg <= width_cnt_next;
			alert_n_reg   <= alert_n_next;
		end
	end

	assign cfg_rd_data           = cfg_reg;
	assign status                = status_reg;
	assign processor_hot_alert_n = alert_n_reg;

	// Helper for the width check: length of the current low pulse, saturating.
	logic [CNT_W-1:0] low_len_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			low_len_reg <= '0;
		end else if (alert_n_reg) begin
			low_len_reg <= '0;
		end else if (low_len_reg != '1) begin
			low_len_reg <= low_len_reg + 1'b1;
		end
	end

	chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		!cfg_rd_data[8] && !cfg_rd_data[0])
		else $error("reserved bits read nonzero");
	chk_clear_restore: assert property (@(posedge clk_sys) disable iff (!rstn)
		clear_evt |=> !cfg_rd_data[CLEAR_BIT] ##1 (cfg_rd_data[CLEAR_BIT] || $past(clear_evt)))
		else $error("clear bit did not return to idle");
	chk_profile_off: assert property (@(posedge clk_sys) disable iff (!rstn)
		!(|profile_en) |=> processor_hot_alert_n)
		else $error("alert active with all profile bits off");
	chk_trigger_alert: assert property (@(posedge clk_sys) disable iff (!rstn)
		trig |=> !processor_hot_alert_n)
		else $error("trigger did not pull alert low");
	chk_min_width: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(processor_hot_alert_n) && $past(alert_on) && $past(state_reg) == ALERT_ACTIVE
		|-> $past(low_len_reg) >= $past(width_cyc) - 1'b1)
		else $error("alert pulse shorter than selected width");
	chk_held_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_reg == ALERT_HELD && alert_on && !clear_evt |=> !processor_hot_alert_n)
		else $error("held alert released without clear");
	chk_ovc_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
		cfg_reg[OVC_SEL_HI:OVC_SEL_LO] == '1 |=> !status.overcurrent && !status.critical)
		else $error("out-of-range threshold code triggered");
	chk_nominal_cmp: assert property (@(posedge clk_sys) disable iff (!rstn)
		$past(rstn) |-> status.nominal == $past(PROD_W'(sense.sensed_ma) * NOM_SENSE_MUL >
			PROD_W'(sense.limit_ma) * NOM_LIM_MUL))
		else $error("nominal comparator mismatch");
	chk_crit_deglitch: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(deg_out[0]) |-> $past(status_reg.critical) && crit_target != '0)
		else $error("critical deglitch rose without a held comparator");
	cov_pulse_done: cover property (@(posedge clk_sys) disable iff (!rstn)
		state_reg == ALERT_ACTIVE ##1 state_reg == ALERT_IDLE);
	cov_held_cleared: cover property (@(posedge clk_sys) disable iff (!rstn)
		state_reg == ALERT_HELD && clear_evt && !trig);
	cov_clear_race: cover property (@(posedge clk_sys) disable iff (!rstn)
		state_reg == ALERT_HELD && clear_evt && trig);
endmodule
`default_nettype wire

// >>> logic/processor_hot_alert_n_pkg.sv
// Constants, field layout and carrier types of the processor-hot alert block.
// Assumes a single 200 MHz system clock shared by every user of this package.
`default_nettype none
package processor_hot_alert_n_pkg;

	// Clock rate and conversion of printed times into cycles.
	localparam int CLK_MHZ = 200;
	function automatic int cyc_from_us(input longint us);
		return int'(us * CLK_MHZ);
	endfunction

	// Printed times, each in its own unit.
	localparam int T_CRIT_DEG0_US = 15;
	localparam int T_CRIT_DEG1_US = 100;
	localparam int T_CRIT_DEG2_US = 400;
	localparam int T_CRIT_DEG3_US = 800;
	localparam int T_SYS_DEG_US   = 20;
	localparam int T_NOM_DEG0_MS  = 1;
	localparam int T_NOM_DEG1_MS  = 50;
	localparam int T_WIDTH0_US    = 100;
	localparam int T_WIDTH1_MS    = 1;
	localparam int T_WIDTH2_MS    = 10;
	localparam int T_WIDTH3_MS    = 5;
	localparam int US_PER_MS      = 1000;

	// Counts short enough to stay fixed.
	localparam int CRIT_DEG0_CYC = cyc_from_us(T_CRIT_DEG0_US);
	localparam int SYS_DEG_CYC   = cyc_from_us(T_SYS_DEG_US);
	localparam int CNT_W         = 24;

	// Configuration register.
	localparam logic [7:0]  CFG_ADDR  = 8'h33;
	localparam logic [15:0] CFG_RESET = 16'h4a54;
	localparam logic [15:0] CFG_WMASK = 16'hfefe;
	localparam int OVC_SEL_HI  = 15;
	localparam int OVC_SEL_LO  = 11;
	localparam int CRIT_DEG_HI = 10;
	localparam int CRIT_DEG_LO = 9;
	localparam int SYS_SEL_HI  = 7;
	localparam int SYS_SEL_LO  = 6;
	localparam int EXT_EN_BIT  = 5;
	localparam int WIDTH_HI    = 4;
	localparam int WIDTH_LO    = 3;
	localparam int CLEAR_BIT   = 2;
	localparam int NOM_DEG_BIT = 1;

	// Bits of the companion profile register that enable each source.
	localparam int PROF_W        = 7;
	localparam int PROF_CRIT_BIT = 5;
	localparam int PROF_NOM_BIT  = 4;
	localparam int PROF_SYS_BIT  = 2;

	// Over-current threshold code decode, in percent of the input current limit.
	localparam int PCT_W = 10;
	localparam logic [4:0]       OVC_CODE_FIRST     = 5'h01;
	localparam logic [4:0]       OVC_CODE_FINE_LAST = 5'h19;
	localparam logic [4:0]       OVC_CODE_COARSE    = 5'h1a;
	localparam logic [4:0]       OVC_CODE_LAST      = 5'h1e;
	localparam logic [PCT_W-1:0] PCT_FINE_BASE      = 10'h06e;
	localparam logic [PCT_W-1:0] PCT_FINE_STEP      = 10'h005;
	localparam logic [PCT_W-1:0] PCT_COARSE_BASE    = 10'h0fa;
	localparam logic [PCT_W-1:0] PCT_COARSE_STEP    = 10'h032;

	// Comparator scaling: sense*100 > lim*pct, sense*1000 > lim*pct*11, sense*10 > lim*11.
	localparam int PROD_W = 40;
	localparam logic [PROD_W-1:0] OVC_SENSE_MUL  = 40'h64;
	localparam logic [PROD_W-1:0] CRIT_SENSE_MUL = 40'h3e8;
	localparam logic [PROD_W-1:0] CRIT_LIM_MUL   = 40'hb;
	localparam logic [PROD_W-1:0] NOM_SENSE_MUL  = 40'ha;
	localparam logic [PROD_W-1:0] NOM_LIM_MUL    = 40'hb;

	// System undervoltage thresholds in mV, indexed by the two-bit select.
	localparam int VOLT_W = 16;
	localparam logic [VOLT_W-1:0] SYS_MULTI_MV [4] = '{16'h1676, 16'h1770, 16'h186a, 16'h1964};
	localparam logic [VOLT_W-1:0] SYS_ONE_MV   [4] = '{16'h0b22, 16'h0c1c, 16'h0d16, 16'h0e10};

	localparam int CUR_W = 16;

	typedef struct packed {
		logic [CUR_W-1:0]  sensed_ma;
		logic [CUR_W-1:0]  limit_ma;
		logic [VOLT_W-1:0] system_rail_mv;
		logic              one_cell;
	} sense_s;

	typedef struct packed {
		logic overcurrent;
		logic critical;
		logic nominal;
		logic undervoltage;
	} status_s;

	typedef enum logic [1:0] {ALERT_IDLE, ALERT_ACTIVE, ALERT_HELD} alert_state_e;

	function automatic logic [PCT_W-1:0] ovc_pct(input logic [4:0] code);
		logic [PCT_W-1:0] pct;
		pct = '0;
		if (code >= OVC_CODE_FIRST && code <= OVC_CODE_FINE_LAST) begin
			pct = PCT_FINE_BASE + PCT_FINE_STEP * PCT_W'(code - OVC_CODE_FIRST);
		end else if (code >= OVC_CODE_COARSE && code <= OVC_CODE_LAST) begin
			pct = PCT_COARSE_BASE + PCT_COARSE_STEP * PCT_W'(code - OVC_CODE_COARSE);
		end
		return pct;
	endfunction

endpackage
`default_nettype wire

// >>> sim/host_proc_model.sv
// Host controller and alert receiver on the far side of the alert block.
// Assumes one shared clk_sys and that the bench calls write_cfg for every write.
`default_nettype none
`timescale 1ns/100ps
module host_proc_model
	import processor_hot_alert_n_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Register writes.
	output logic             cfg_wr_en,
	output logic      [15:0] cfg_wr_data,
	// Alert pin.
	input  wire logic        processor_hot_alert_n,
	output int               low_len
);
	int run;
	initial begin
		cfg_wr_en = 1'b0;
		cfg_wr_data = 16'h0000;
		run = 0;
		low_len = 0;
	end
	// A word with the clear bit at zero ends a held alert when no trigger is live.
	task automatic write_cfg(input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		cfg_wr_en = 1'b1;
		cfg_wr_data = d;
		@(posedge clk_sys);
		#1;
		cfg_wr_en = 1'b0;
		// The bus is idle now, so the data lines must not keep showing the word.
		cfg_wr_data = ~d;
	endtask
	// Length of the latest low pulse in cycles, seen as the processor would.
	always @(posedge clk_sys) begin
		if (processor_hot_alert_n === 1'b0 && rstn === 1'b1) begin
			run = run + 1;
		end else if (run != 0) begin
			low_len = run;
			run = 0;
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb_processor_hot_alert_config.sv
// Self-checking bench for the processor-hot alert block.
// Assumes the host model makes every register write; counts are the shortened ones.
`default_nettype none
`timescale 1ns/100ps
module tb_processor_hot_alert_config
	import processor_hot_alert_n_pkg::*;
;
	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] sen;
		logic [15:0] rail;
		logic        one;
		logic [3:0]  st;
	} row_s;
	localparam sense_s SAFE = '{16'h01f4, 16'h03e8, 16'h1b58, 1'b0};
	localparam sense_s HOT  = '{16'h07d0, 16'h03e8, 16'h1b58, 1'b0};
	// Shortened timer counts keep the run inside its cycle budget; fixed counts stay real.
	localparam int     CD1  = 20;
	localparam int     CD2  = 40;
	localparam int     CD3  = 60;
	localparam int     ND0  = 30;
	localparam int     ND1  = 50;
	localparam int     WD0  = 10;
	localparam int     WD1  = 20;
	localparam int     WD2  = 40;
	localparam int     WD3  = 30;
	logic        clk_sys;
	logic        rstn;
	logic        cfg_wr_en;
	logic [15:0] cfg_wr_data;
	logic [15:0] cfg_rd_data;
	logic [6:0]  profile_en;
	sense_s      sense;
	logic        processor_hot_alert_n;
	status_s     status;
	int          low_len;
	int          miscompares;
	int          check_count;
	int          wtab [4] = '{WD0, WD1, WD2, WD3};
	int          dtab [4] = '{CRIT_DEG0_CYC + 2, CD1 + 2, CD2 + 2, CD3 + 2};
	row_s        rows [12] = '{
		'{16'h4a55, 16'h0640, 16'h176f, 1'b0, 4'hb},
		'{16'h0854, 16'h044d, 16'h1770, 1'b0, 4'ha},
		'{16'hc854, 16'h09e3, 16'h1b58, 1'b0, 4'he},
		'{16'hd054, 16'h09c4, 16'h1b58, 1'b0, 4'h2},
		'{16'hf054, 16'h1357, 16'h1b58, 1'b0, 4'he},
		'{16'hf854, 16'hea60, 16'h1b58, 1'b0, 4'h2},
		'{16'h0054, 16'hea60, 16'h1b58, 1'b0, 4'h2},
		'{16'h4a14, 16'h01f4, 16'h0b21, 1'b1, 4'h1},
		'{16'h4ad4, 16'h01f4, 16'h0e10, 1'b1, 4'h0},
		'{16'h4a94, 16'h01f4, 16'h1869, 1'b0, 4'h1},
		'{16'h4a54, 16'h03e8, 16'h0b22, 1'b1, 4'h1},
		'{16'h4a7e, 16'h01f4, 16'h1b58, 1'b0, 4'h0}};

	processor_hot_alert_config #(
		.CRIT_DEG1_CYC(CD1), .CRIT_DEG2_CYC(CD2), .CRIT_DEG3_CYC(CD3),
		.NOM_DEG0_CYC(ND0), .NOM_DEG1_CYC(ND1), .WIDTH0_CYC(WD0),
		.WIDTH1_CYC(WD1), .WIDTH2_CYC(WD2), .WIDTH3_CYC(WD3)
	) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .cfg_wr_en(cfg_wr_en),
		.cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
		.profile_en(profile_en), .sense(sense),
		.processor_hot_alert_n(processor_hot_alert_n), .status(status)
	);

	host_proc_model host_u (
		.clk_sys(clk_sys), .rstn(rstn), .cfg_wr_en(cfg_wr_en),
		.cfg_wr_data(cfg_wr_data),
		.processor_hot_alert_n(processor_hot_alert_n), .low_len(low_len)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic final_report();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: register %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_st(input status_s g, input logic [3:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: status %b expected %b", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: alert pin %b expected %b", $time, g, e);
		end
	endtask

	task automatic chk_cnt(input int g, input int lo, input int hi);
		check_count++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("Error at %0t: count %0d outside %0d..%0d", $time, g, lo, hi);
		end
	endtask

	// Applies a source and measures cycles until the pin falls.
	task automatic trig(input logic [6:0] p, input logic [15:0] c, input sense_s s, input int d);
		int n;
		host_u.write_cfg(c);
		profile_en = p;
		step(2);
		sense = s;
		n = 0;
		while (processor_hot_alert_n !== 1'b0 && n < d + 20) begin
			step(1);
			n++;
		end
		chk_cnt(n, d, d);
	endtask

	// Removes the source and checks the low time against the width.
	task automatic release_src(input int w);
		int n;
		sense = SAFE;
		n = 0;
		while (processor_hot_alert_n !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		// The far side latches the pulse length on the edge after the pin rises.
		step(1);
		chk_cnt(low_len, w, w + 4);
	endtask

	initial begin
		rstn = 1'b0;
		profile_en = 7'h00;
		sense = SAFE;
		miscompares = 0;
		check_count = 0;
		step(16);
		chk_reg(cfg_rd_data, 16'h4a54);
		chk_pin(processor_hot_alert_n, 1'b1);
		chk_st(status, 4'h0);
		rstn = 1'b1;
		// Bit 6 alone keeps the function on with no modelled source enabled.
		profile_en = 7'h40;
		foreach (rows[i]) begin
			host_u.write_cfg(rows[i].cfg);
			sense = '{rows[i].sen, 16'h03e8, rows[i].rail, rows[i].one};
			step(3);
			chk_reg(cfg_rd_data, rows[i].cfg & 16'hfefe);
			chk_st(status, rows[i].st);
			chk_pin(processor_hot_alert_n, 1'b1);
		end
		for (int i = 0; i < 4; i++) begin
			trig(7'h20, {5'h09, 2'(i), 4'h2, 2'(i), 3'h4}, HOT, dtab[i]);
			release_src(wtab[i]);
		end
		for (int j = 0; j < 2; j++) begin
			trig(7'h10, 16'h4a54 | 16'(j << 1), HOT, (j == 0 ? ND0 : ND1) + 2);
			release_src(WD2);
		end
		trig(7'h34, 16'h4a44, '{16'h01f4, 16'h03e8, 16'h1000, 1'b0}, SYS_DEG_CYC + 2);
		release_src(WD0);
		trig(7'h20, 16'h4a74, HOT, CD1 + 2);
		sense = SAFE;
		step(100);
		chk_pin(processor_hot_alert_n, 1'b0);
		host_u.write_cfg(16'h4a70);
		chk_reg(cfg_rd_data, 16'h4a70);
		step(1);
		chk_pin(processor_hot_alert_n, 1'b1);
		step(1);
		chk_reg(cfg_rd_data, 16'h4a74);
		trig(7'h20, 16'h4a74, HOT, CD1 + 2);
		// A clear that meets a live trigger must leave the alert held.
		host_u.write_cfg(16'h4a70);
		chk_pin(processor_hot_alert_n, 1'b0);
		sense = SAFE;
		profile_en = 7'h00;
		step(2);
		chk_pin(processor_hot_alert_n, 1'b1);
		sense = HOT;
		step(60);
		chk_pin(processor_hot_alert_n, 1'b1);
		host_u.write_cfg(16'hffff);
		chk_reg(cfg_rd_data, 16'hfefe);
		rstn = 1'b0;
		step(2);
		chk_reg(cfg_rd_data, 16'h4a54);
		rstn = 1'b1;
		step(1);
		chk_reg(cfg_rd_data, 16'h4a54);
		chk_st(status, 4'he);
		step(1);
		chk_pin(processor_hot_alert_n, 1'b1);
		final_report();
	end

	// The planned sequence needs about 8000 cycles; five times that means a hang.
	initial begin
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire
